// >>> dv/sgm_properties.sv
`timescale 1ns/1ps
module sgm_properties (
   // clock and reset
   input wire logic i_clk_sys,
   input wire logic i_arst_n,
   // bus side
   input wire logic i_ce,
   input wire logic i_hsel,
   input wire logic [1:0] i_htrans,
   input wire logic i_hwrite,
   input wire logic i_hready,
   input wire logic o_hreadyout,
   input wire logic o_hresp,
   input wire logic [sgm_pkg::BUS_W-1:0] o_hrdata,
   // event outputs
   input wire logic o_irq_width_acq,
   input wire logic o_irq_period_acq,
   input wire logic o_irq_match,
   input wire logic o_meas_clk_req
);
   import sgm_pkg::*;
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (!i_arst_n);
   // accepted transfer, and a write data phase one cycle later
   logic taken;
   logic wr_dp;
   assign taken = i_hsel & i_hready & i_htrans[1] & i_ce;
   always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
      if (!i_arst_n) begin
         wr_dp <= 1'b0;
      end else if (i_ce) begin
         wr_dp <= taken & i_hwrite;
      end
   end
   // exactly one wait state per transfer
   sequence s_one_wait;
      !o_hreadyout ##1 o_hreadyout;
   endsequence
   // outputs only move for their own causes; flags drop only after a write
   a_wait_one: assert property (taken |=> s_one_wait)
      else $error("transfer wait state wrong");
   a_resp_okay: assert property (o_hresp == HRESP_OKAY)
      else $error("response not okay");
   a_ready_cause: assert property ($fell(o_hreadyout) |-> $past(taken))
      else $error("wait state without transfer");
   a_rdata_hold: assert property ($changed(o_hrdata) |-> $rose(o_hreadyout))
      else $error("read data moved mid transfer");
   a_clkreq_cause: assert property ($changed(o_meas_clk_req) |-> $past(wr_dp) || $past(wr_dp, 2))
      else $error("clock request moved without write");
   a_width_irq_drop: assert property ($fell(o_irq_width_acq) |-> $past(wr_dp) || $past(wr_dp, 2))
      else $error("width irq dropped without write");
   a_period_irq_drop: assert property ($fell(o_irq_period_acq) |-> $past(wr_dp) || $past(wr_dp, 2))
      else $error("period irq dropped without write");
   a_match_irq_drop: assert property ($fell(o_irq_match) |-> $past(wr_dp) || $past(wr_dp, 2))
      else $error("match irq dropped without write");
endmodule // sgm_properties

bind sgm_signal_measurement_timer sgm_properties i_chk (.i_clk_sys(i_clk_sys),
   .i_arst_n(i_arst_n), .i_ce(i_ce), .i_hsel(i_hsel), .i_htrans(i_htrans), .i_hwrite(i_hwrite),
   .i_hready(i_hready), .o_hreadyout(o_hreadyout), .o_hresp(o_hresp), .o_hrdata(o_hrdata),
   .o_irq_width_acq(o_irq_width_acq), .o_irq_period_acq(o_irq_period_acq),
   .o_irq_match(o_irq_match), .o_meas_clk_req(o_meas_clk_req));

// >>> dv/sgm_signal_measurement_timer_tb.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin error_cnt++; $display("BAD %s exp %h got %h", n, e, g); end end
module sgm_signal_measurement_timer_tb;
   import sgm_pkg::*;
   // bench state
   logic clk = 1'b0;
   logic arst_n = 1'b0;
   logic win = 1'b0;
   logic sig_en = 1'b0;
   logic hwrite = 1'b0;
   logic [1:0] htrans = 2'h0;
   logic [31:0] haddr = 32'h0000_0000;
   logic [31:0] hwdata = 32'h0000_0000;
   logic [31:0] rd, p, hrdata;
   logic mclk, wnd, sgl, rdy, resp, irq_w, irq_p, irq_m, creq;
   int error_cnt = 0;
   int comparisons = 0;
   int cyc = 0;
   // offset, write value, read-back value
   logic [55:0] rows [7] = '{{8'h00, 24'h00_007F, 24'h00_003F}, {8'h04, 24'h00_003B, 24'h00_000B},
      {8'h0C, 24'hFF_FFFF, 24'hFF_FFFF}, {8'h18, 24'h34_5678, 24'h34_5678},
      {8'h10, 24'h00_0077, 24'h00_0000}, {8'h24, 24'hFF_FFFF, 24'h00_0000},
      {8'h08, 24'h00_0007, 24'h00_0000}};
   // clock and hang guard
   always #4 clk = ~clk;
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         error_cnt++;
         finish_test();
      end
   end
   sgm_source_model i_src (.i_clk_sys(clk), .i_arst_n(arst_n), .i_win(win), .i_sig_en(sig_en),
      .o_meas_clk(mclk), .o_window(wnd), .o_signal(sgl));
   sgm_signal_measurement_timer i_dut (.i_clk_sys(clk), .i_arst_n(arst_n), .i_ce(1'b1),
      .i_window_input(wnd), .i_signal_input(sgl), .i_meas_clk(mclk), .i_hsel(1'b1),
      .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata),
      .i_hready(rdy), .o_hreadyout(rdy), .o_hresp(resp), .o_hrdata(hrdata),
      .o_irq_width_acq(irq_w), .o_irq_period_acq(irq_p), .o_irq_match(irq_m),
      .o_meas_clk_req(creq));
   // one word transfer, waiting on ready rather than a fixed count
   task automatic bus(input logic [7:0] a, input logic wr, input logic [23:0] d);
      @(posedge clk);
      haddr <= {24'h00_0000, a};
      hwrite <= wr;
      htrans <= 2'h2;
      do @(posedge clk); while (rdy !== 1'b1);
      htrans <= 2'h0;
      hwdata <= {8'h00, d};
      do @(posedge clk); while (rdy !== 1'b1);
      rd = hrdata;
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [23:0] e);
      bus(a, 1'b0, 24'h00_0000);
      `CHK("register", {8'h00, e}, rd)
   endtask
   // measurement clock edges, then realign to the system clock
   task automatic ticks(input int n);
      repeat (n) @(posedge mclk);
      @(posedge clk);
   endtask
   task automatic finish_test();
      if (error_cnt == 0 && comparisons > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   initial begin
      repeat (4) @(posedge clk);
      arst_n <= 1'b1;
      foreach (rows[i]) begin
         bus(rows[i][55:48], 1'b1, rows[i][47:24]);
         rdchk(rows[i][55:48], rows[i][23:0]);
      end
      for (int m = 0; m < 16; m++) begin
         bus(8'h04, 1'b1, 24'(m));
         rdchk(8'h04, 24'(m));
      end
      // manual copies and clear work with the block disabled
      bus(8'h0C, 1'b1, 24'h00_0055);
      bus(8'h08, 1'b1, 24'h00_0080);
      rdchk(8'h10, 24'h00_0055);
      rdchk(8'h08, 24'h00_0000);
      rdchk(8'h1C, 24'h00_0002);
      bus(8'h20, 1'b1, 24'h00_0002);
      repeat (2) @(posedge clk);
      `CHK("period irq", 1'b1, irq_p)
      bus(8'h1C, 1'b1, 24'h00_0002);
      repeat (2) @(posedge clk);
      `CHK("period irq", 1'b0, irq_p)
      bus(8'h08, 1'b1, 24'h00_0040);
      rdchk(8'h14, 24'h00_0055);
      bus(8'h08, 1'b1, 24'h00_0020);
      rdchk(8'h0C, 24'h00_0000);
      // capture at 1:2, window edges eight clock edges apart
      bus(8'h1C, 1'b1, 24'h00_0007);
      bus(8'h20, 1'b1, 24'h00_0001);
      bus(8'h00, 1'b1, 24'h00_0081);
      bus(8'h04, 1'b1, 24'h00_00C7);
      ticks(10);
      win <= 1'b1;
      ticks(8);
      win <= 1'b0;
      ticks(6);
      bus(8'h10, 1'b0, 24'h00_0000);
      p = rd;
      `CHK("period latch", 1'b1, p != 32'h0000_0000)
      rdchk(8'h14, p[23:0] + 24'h00_0004);
      bus(8'h0C, 1'b0, 24'h00_0000);
      `CHK("counter kept", 1'b1, rd >= p + 32'h0000_0004)
      `CHK("width irq", 1'b1, irq_w)
      // counter mode, single acquisition of five pulses
      bus(8'h1C, 1'b1, 24'h00_0007);
      bus(8'h04, 1'b1, 24'h00_0008);
      bus(8'h00, 1'b1, 24'h00_0080);
      bus(8'h08, 1'b1, 24'h00_0020);
      bus(8'h04, 1'b1, 24'h00_0088);
      sig_en <= 1'b1;
      repeat (5) @(posedge sgl);
      @(posedge clk);
      sig_en <= 1'b0;
      ticks(4);
      win <= 1'b1;
      ticks(4);
      win <= 1'b0;
      ticks(6);
      rdchk(8'h14, 24'h00_0005);
      rdchk(8'h04, 24'h00_0008);
      // windowed counter, repeat; window inverted so a low pin opens it
      win <= 1'b1;
      bus(8'h00, 1'b1, 24'h00_0090);
      bus(8'h08, 1'b1, 24'h00_0020);
      bus(8'h1C, 1'b1, 24'h00_0007);
      bus(8'h04, 1'b1, 24'h00_00CA);
      win <= 1'b0;
      ticks(2);
      sig_en <= 1'b1;
      repeat (3) @(posedge sgl);
      @(posedge clk);
      sig_en <= 1'b0;
      ticks(2);
      rdchk(8'h08, 24'h00_0007);
      win <= 1'b1;
      ticks(2);
      win <= 1'b0;
      ticks(2);
      rdchk(8'h14, 24'h00_0003);
      rdchk(8'h10, 24'h00_0003);
      rdchk(8'h04, 24'h00_00CA);
      rdchk(8'h1C, 24'h00_0003);
      // period match in timer mode, then enable dropped
      bus(8'h18, 1'b1, 24'h00_0003);
      bus(8'h20, 1'b1, 24'h00_0004);
      bus(8'h08, 1'b1, 24'h00_0020);
      bus(8'h04, 1'b1, 24'h00_00C0);
      bus(8'h00, 1'b1, 24'h00_00A0);
      for (int i = 0; i < 200 && irq_m !== 1'b1; i++) @(posedge clk);
      `CHK("match irq", 1'b1, irq_m)
      `CHK("clock request", 1'b1, creq)
      // halt set: counter parks at the period limit
      ticks(8);
      rdchk(8'h0C, 24'h00_0003);
      bus(8'h00, 1'b1, 24'h00_0000);
      repeat (2) @(posedge clk);
      `CHK("clock request", 1'b0, creq)
      rdchk(8'h04, 24'h00_00C0);
      bus(8'h1C, 1'b1, 24'h00_0004);
      rdchk(8'h1C, 24'h00_0003);
      // reset with the block disabled and the run bit still set
      arst_n <= 1'b0;
      repeat (4) @(posedge clk);
      arst_n <= 1'b1;
      rdchk(8'h18, 24'hFF_FFFF);
      rdchk(8'h04, 24'h00_0000);
      finish_test();
   end
endmodule // sgm_signal_measurement_timer_tb

// >>> dv/sgm_source_model.sv
`timescale 1ns/1ps
module sgm_source_model #(
   parameter int MHALF = 3,
   parameter int SHALF = 5
) (
   // clock and reset
   input wire logic i_clk_sys,
   input wire logic i_arst_n,
   // requests from the bench
   input wire logic i_win,
   input wire logic i_sig_en,
   // sources seen by the timer
   output logic o_meas_clk,
   output logic o_window,
   output logic o_signal
);
   int mcnt;
   int scnt;
   // free-running clock; signal rests low when idle so no stale pulse leaks in
   always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
      if (!i_arst_n) begin
         mcnt <= 0;
         scnt <= 0;
         o_meas_clk <= 1'b0;
         o_window <= 1'b0;
         o_signal <= 1'b0;
      end else begin
         mcnt <= (mcnt == MHALF - 1) ? 0 : mcnt + 1;
         o_meas_clk <= (mcnt == MHALF - 1) ? ~o_meas_clk : o_meas_clk;
         o_window <= i_win;
         scnt <= (i_sig_en && scnt != SHALF - 1) ? scnt + 1 : 0;
         o_signal <= !i_sig_en ? 1'b0 : ((scnt == SHALF - 1) ? ~o_signal : o_signal);
      end
   end
endmodule // sgm_source_model

// >>> inc/sgm_pkg.sv
package sgm_pkg;
   // datapath widths
   localparam int unsigned CNT_W = 24;
   localparam int unsigned REG_W = 8;
   localparam int unsigned BUS_W = 32;
   localparam int unsigned OFS_W = 8;
   localparam int unsigned PRESC_W = 3;
   localparam int unsigned IRQ_N = 3;

   // register byte offsets
   localparam logic [OFS_W-1:0] OFS_CONTROL_0 = 8'h00;
   localparam logic [OFS_W-1:0] OFS_CONTROL_1 = 8'h04;
   localparam logic [OFS_W-1:0] OFS_STATUS = 8'h08;
   localparam logic [OFS_W-1:0] OFS_COUNTER = 8'h0C;
   localparam logic [OFS_W-1:0] OFS_PERIOD_LATCH = 8'h10;
   localparam logic [OFS_W-1:0] OFS_WIDTH_LATCH = 8'h14;
   localparam logic [OFS_W-1:0] OFS_PERIOD_LIMIT = 8'h18;
   localparam logic [OFS_W-1:0] OFS_IRQ_FLAG = 8'h1C;
   localparam logic [OFS_W-1:0] OFS_IRQ_ENABLE = 8'h20;

   // irq flag / enable bit positions
   localparam int unsigned IRQ_WIDTH_BIT = 0;
   localparam int unsigned IRQ_PERIOD_BIT = 1;
   localparam int unsigned IRQ_MATCH_BIT = 2;

   // reset values
   localparam logic [CNT_W-1:0] CNT_ZERO = 24'h00_0000;
   localparam logic [CNT_W-1:0] CNT_ONE = 24'h00_0001;
   localparam logic [CNT_W-1:0] PERIOD_LIMIT_RST = 24'hFF_FFFF;
   localparam logic [REG_W-1:0] REG_RST = 8'h00;
   localparam logic [IRQ_N-1:0] IRQ_RST = 3'h0;
   localparam logic [BUS_W-1:0] BUS_ZERO = 32'h0000_0000;

   // prescaler terminal counts for 1:1, 1:2, 1:4, 1:8
   localparam logic [PRESC_W-1:0] PRESC_MAX_DIV1 = 3'h0;
   localparam logic [PRESC_W-1:0] PRESC_MAX_DIV2 = 3'h1;
   localparam logic [PRESC_W-1:0] PRESC_MAX_DIV4 = 3'h3;
   localparam logic [PRESC_W-1:0] PRESC_MAX_DIV8 = 3'h7;

   // ahb-lite
   localparam int unsigned HTRANS_ACTIVE_BIT = 1;
   localparam logic HRESP_OKAY = 1'b0;

   // operating modes; 4'hB..4'hF are reserved
   typedef enum logic [3:0] {
      MODE_TIMER = 4'h0,
      MODE_GATED_TIMER = 4'h1,
      MODE_PERIOD_DUTY = 4'h2,
      MODE_HIGH_LOW = 4'h3,
      MODE_WIN_MEASURE = 4'h4,
      MODE_GATED_WIN = 4'h5,
      MODE_TOF = 4'h6,
      MODE_CAPTURE = 4'h7,
      MODE_COUNTER = 4'h8,
      MODE_GATED_CNT = 4'h9,
      MODE_WIN_CNT = 4'hA
   } sgm_mode_t;

   // control register 0 layout
   typedef struct packed {
      logic en;
      logic rsv;
      logic halt_at_period;
      logic window_invert;
      logic signal_invert;
      logic clock_edge_invert;
      logic [1:0] clock_prescale_sel;
   } sgm_ctl0_t;

   // control register 1 layout
   typedef struct packed {
      logic run_bit;
      logic repeat_acq;
      logic [1:0] rsv;
      logic [3:0] mode;
   } sgm_ctl1_t;

   // status register layout
   typedef struct packed {
      logic manual_period_copy;
      logic manual_width_copy;
      logic manual_clear;
      logic [1:0] rsv;
      logic running_flag;
      logic window_open_flag;
      logic acquire_busy_flag;
   } sgm_stat_t;
endpackage

// >>> logic/sgm_signal_measurement_timer.sv
`timescale 1ns/1ps
module sgm_signal_measurement_timer (
   // clock, reset, enable
   input wire logic i_clk_sys,
   input wire logic i_arst_n,
   input wire logic i_ce,
   // measured inputs from pins or other peripherals
   input wire logic i_window_input,
   input wire logic i_signal_input,
   input wire logic i_meas_clk,
   // ahb-lite slave
   input wire logic i_hsel,
   input wire logic [sgm_pkg::BUS_W-1:0] i_haddr,
   input wire logic [1:0] i_htrans,
   input wire logic i_hwrite,
   input wire logic [2:0] i_hsize,
   input wire logic [sgm_pkg::BUS_W-1:0] i_hwdata,
   input wire logic i_hready,
   output logic o_hreadyout,
   output logic o_hresp,
   output logic [sgm_pkg::BUS_W-1:0] o_hrdata,
   // interrupt triggers and clock request
   output logic o_irq_width_acq,
   output logic o_irq_period_acq,
   output logic o_irq_match,
   output logic o_meas_clk_req
);
   import sgm_pkg::*;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_WAIT = 3'b010,
      ST_ACTIVE = 3'b100
   } sgm_state_t;

   // synchroniser and edge history
   logic [1:0] win_sync, sig_sync, clk_sync;
   logic win_prev, sig_prev, clk_prev;
   logic next_win_prev, next_sig_prev, next_clk_prev;
   logic win_lvl, sig_lvl, clk_lvl;
   logic win_rise, win_fall, sig_rise, clk_edge;

   // core state
   sgm_state_t state, next_state;
   sgm_ctl0_t ctl0, next_ctl0;
   sgm_ctl1_t ctl1, next_ctl1;
   sgm_stat_t stat, next_stat;
   logic [CNT_W-1:0] measure_counter, next_measure_counter;
   logic [CNT_W-1:0] period_latch, next_period_latch;
   logic [CNT_W-1:0] pulse_width_latch, next_pulse_width_latch;
   logic [CNT_W-1:0] period_limit, next_period_limit;
   logic [PRESC_W-1:0] presc_cnt, next_presc_cnt;
   logic [IRQ_N-1:0] irq_flag, next_irq_flag;
   logic [IRQ_N-1:0] irq_enable, next_irq_enable;
   logic next_irq_width, next_irq_period, next_irq_match, next_clk_req;

   // bus state
   logic dph, next_dph;
   logic dwrite, next_dwrite;
   logic dlegal, next_dlegal;
   logic [OFS_W-1:0] dofs, next_dofs;
   logic next_hreadyout;
   logic [BUS_W-1:0] next_hrdata;
   logic wr_stb;

   // status fields derived from live state
   logic running, window_open, acq_busy;

   // two-flop synchronisers; the first stage feeds only the second
   always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
      if (!i_arst_n) begin
         win_sync <= 2'h0;
         sig_sync <= 2'h0;
         clk_sync <= 2'h0;
      end else if (i_ce) begin
         win_sync <= {win_sync[0], i_window_input};
         sig_sync <= {sig_sync[0], i_signal_input};
         clk_sync <= {clk_sync[0], i_meas_clk};
      end
   end

   // polarity before edge detection, so inverted inputs see the active edge
   always_comb begin
      win_lvl = win_sync[1] ^ ctl0.window_invert;
      sig_lvl = sig_sync[1] ^ ctl0.signal_invert;
      clk_lvl = clk_sync[1] ^ ctl0.clock_edge_invert;
      win_rise = win_lvl & ~win_prev;
      win_fall = ~win_lvl & win_prev;
      sig_rise = sig_lvl & ~sig_prev;
      clk_edge = clk_lvl & ~clk_prev;
      // history tracks the input while disabled: no false edge on enable
      next_win_prev = win_lvl;
      next_sig_prev = sig_lvl;
      next_clk_prev = clk_lvl;
      running = ctl0.en & ctl1.run_bit & (state == ST_ACTIVE);
      window_open = ctl0.en & win_lvl;
      acq_busy = ctl0.en & (state != ST_IDLE);
   end

   always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
      if (!i_arst_n) begin
         win_prev <= 1'b0;
         sig_prev <= 1'b0;
         clk_prev <= 1'b0;
      end else if (i_ce) begin
         win_prev <= next_win_prev;
         sig_prev <= next_sig_prev;
         clk_prev <= next_clk_prev;
      end
   end

   // ahb-lite slave: one wait state per transfer, data from a flop
   always_comb begin
      logic accept;
      accept = i_hsel & i_hready & i_htrans[HTRANS_ACTIVE_BIT];
      next_dph = accept;
      next_dwrite = accept ? i_hwrite : dwrite;
      next_dofs = accept ? i_haddr[OFS_W-1:0] : dofs;
      next_dlegal = accept ? (i_haddr[BUS_W-1:OFS_W] == '0) : dlegal;
      next_hreadyout = accept ? 1'b0 : (dph ? 1'b1 : o_hreadyout);
      next_hrdata = o_hrdata;
      wr_stb = dph & dwrite & dlegal;
      if (dph & ~dwrite) begin
         next_hrdata = BUS_ZERO; // unmapped reads return zero
         if (dlegal) begin
            unique case (dofs)
               OFS_CONTROL_0: next_hrdata = {24'h00_0000, ctl0};
               OFS_CONTROL_1: next_hrdata = {24'h00_0000, ctl1};
               OFS_STATUS: next_hrdata = {24'h00_0000, stat.manual_period_copy,
                  stat.manual_width_copy, stat.manual_clear, 2'h0,
                  running, window_open, acq_busy};
               OFS_COUNTER: next_hrdata = {8'h00, measure_counter};
               OFS_PERIOD_LATCH: next_hrdata = {8'h00, period_latch};
               OFS_WIDTH_LATCH: next_hrdata = {8'h00, pulse_width_latch};
               OFS_PERIOD_LIMIT: next_hrdata = {8'h00, period_limit};
               OFS_IRQ_FLAG: next_hrdata = {29'h0000_0000, irq_flag};
               OFS_IRQ_ENABLE: next_hrdata = {29'h0000_0000, irq_enable};
               default: next_hrdata = BUS_ZERO;
            endcase
         end
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
      if (!i_arst_n) begin
         dph <= 1'b0;
         dwrite <= 1'b0;
         dlegal <= 1'b0;
         dofs <= OFS_CONTROL_0;
         o_hreadyout <= 1'b1;
         o_hresp <= HRESP_OKAY;
         o_hrdata <= BUS_ZERO;
      end else if (i_ce) begin
         dph <= next_dph;
         dwrite <= next_dwrite;
         dlegal <= next_dlegal;
         dofs <= next_dofs;
         o_hreadyout <= next_hreadyout;
         o_hresp <= HRESP_OKAY;
         o_hrdata <= next_hrdata;
      end
   end

   // measurement core: prescaler, mode sequencing, latches, flags
   always_comb begin
      logic tick, inc, clr, ld_cpr, ld_cpw, match, hw_stop;
      logic [PRESC_W-1:0] presc_max;
      logic [IRQ_N-1:0] irq_evt;
      tick = 1'b0;
      inc = 1'b0;
      clr = 1'b0;
      ld_cpr = 1'b0;
      ld_cpw = 1'b0;
      match = 1'b0;
      hw_stop = 1'b0;
      presc_max = PRESC_MAX_DIV1;
      irq_evt = IRQ_RST;
      next_state = state;
      next_ctl0 = ctl0;
      next_ctl1 = ctl1;
      next_stat = stat;
      next_measure_counter = measure_counter;
      next_period_latch = period_latch;
      next_pulse_width_latch = pulse_width_latch;
      next_period_limit = period_limit;
      next_presc_cnt = presc_cnt;
      next_irq_enable = irq_enable;

      unique case (ctl0.clock_prescale_sel)
         2'h0: presc_max = PRESC_MAX_DIV1;
         2'h1: presc_max = PRESC_MAX_DIV2;
         2'h2: presc_max = PRESC_MAX_DIV4;
         2'h3: presc_max = PRESC_MAX_DIV8;
      endcase

      if (!ctl0.en) begin
         // internal state only; register contents stay as written
         next_state = ST_IDLE;
         next_presc_cnt = '0;
      end else begin
         if (ctl1.run_bit && clk_edge) begin
            if (presc_cnt == presc_max) begin
               tick = 1'b1;
               next_presc_cnt = '0;
            end else begin
               next_presc_cnt = presc_cnt + 3'h1;
            end
         end
         unique case (state)
            ST_IDLE: begin
               if (ctl1.run_bit) begin
                  // modes that start on run rather than on a window edge
                  if (ctl1.mode == MODE_CAPTURE || ctl1.mode == MODE_COUNTER ||
                      ctl1.mode < MODE_WIN_MEASURE) begin
                     next_state = ST_ACTIVE;
                  end else begin
                     next_state = ST_WAIT;
                  end
               end
            end
            ST_WAIT: begin
               if (!ctl1.run_bit) begin
                  next_state = ST_IDLE;
               end else if (win_rise) begin
                  next_state = ST_ACTIVE;
               end
            end
            ST_ACTIVE: begin
               if (!ctl1.run_bit) begin
                  next_state = ST_IDLE;
               end else begin
                  unique case (ctl1.mode)
                     MODE_GATED_WIN: begin
                        inc = tick & sig_lvl;
                        ld_cpr = win_rise;
                        clr = win_rise;
                     end
                     MODE_TOF: begin
                        inc = tick;
                        if (sig_rise) begin
                           ld_cpr = 1'b1;
                           clr = 1'b1;
                           next_state = ST_WAIT;
                        end else if (win_rise) begin
                           ld_cpw = 1'b1;
                           clr = 1'b1;
                        end
                     end
                     MODE_CAPTURE: begin
                        inc = tick;
                        ld_cpr = win_rise;
                        ld_cpw = win_fall;
                     end
                     MODE_COUNTER: begin
                        inc = sig_rise;
                        ld_cpw = win_fall;
                     end
                     MODE_GATED_CNT: begin
                        inc = sig_rise & win_lvl;
                        if (win_fall) begin
                           ld_cpw = 1'b1;
                           next_state = ST_WAIT;
                        end
                     end
                     MODE_WIN_CNT: begin
                        inc = sig_rise;
                        ld_cpw = win_fall;
                        ld_cpr = win_rise;
                        clr = win_rise;
                     end
                     MODE_TIMER, MODE_GATED_TIMER, MODE_PERIOD_DUTY,
                     MODE_HIGH_LOW, MODE_WIN_MEASURE: begin
                        inc = tick; // basic timing only in these modes
                     end
                     default: inc = 1'b0;
                  endcase
               end
            end
            default: next_state = ST_IDLE;
         endcase
         hw_stop = (ld_cpr | ld_cpw) & ~ctl1.repeat_acq;
         if (hw_stop) begin
            next_state = ST_IDLE;
            next_ctl1.run_bit = 1'b0;
         end
      end

      // counting with period match, then hardware clear
      if (inc) begin
         if (measure_counter == period_limit) begin
            match = 1'b1;
            if (!ctl0.halt_at_period) begin
               next_measure_counter = CNT_ZERO;
            end
         end else begin
            next_measure_counter = measure_counter + CNT_ONE;
         end
      end
      if (ld_cpr) begin
         next_period_latch = measure_counter;
      end
      if (ld_cpw) begin
         next_pulse_width_latch = measure_counter;
      end
      if (clr) begin
         next_measure_counter = CNT_ZERO;
      end

      // manual requests complete in one cycle and self-clear
      if (stat.manual_period_copy) begin
         next_period_latch = measure_counter;
         next_stat.manual_period_copy = 1'b0;
      end
      if (stat.manual_width_copy) begin
         next_pulse_width_latch = measure_counter;
         next_stat.manual_width_copy = 1'b0;
      end
      if (stat.manual_clear) begin
         next_measure_counter = CNT_ZERO;
         next_stat.manual_clear = 1'b0;
      end

      irq_evt[IRQ_WIDTH_BIT] = ld_cpw | stat.manual_width_copy;
      irq_evt[IRQ_PERIOD_BIT] = ld_cpr | stat.manual_period_copy;
      irq_evt[IRQ_MATCH_BIT] = match;
      next_irq_flag = irq_flag | irq_evt;

      // software writes; a write to control 1 overrides a hardware stop
      if (wr_stb) begin
         unique case (dofs)
            OFS_CONTROL_0: begin
               next_ctl0 = i_hwdata[REG_W-1:0];
               next_ctl0.rsv = 1'b0;
            end
            OFS_CONTROL_1: begin
               next_ctl1 = i_hwdata[REG_W-1:0];
               next_ctl1.rsv = 2'h0;
            end
            OFS_STATUS: begin
               // writing one requests; zero leaves a pending request alone
               next_stat.manual_period_copy = stat.manual_period_copy | i_hwdata[7];
               next_stat.manual_width_copy = stat.manual_width_copy | i_hwdata[6];
               next_stat.manual_clear = stat.manual_clear | i_hwdata[5];
            end
            OFS_COUNTER: next_measure_counter = i_hwdata[CNT_W-1:0];
            OFS_PERIOD_LIMIT: next_period_limit = i_hwdata[CNT_W-1:0];
            OFS_IRQ_FLAG: begin
               // write one to clear; a same-cycle event still sets the flag
               next_irq_flag = (irq_flag & ~i_hwdata[IRQ_N-1:0]) | irq_evt;
            end
            OFS_IRQ_ENABLE: next_irq_enable = i_hwdata[IRQ_N-1:0];
            default: next_irq_enable = irq_enable;
         endcase
      end

      // triggers are formed in the system clock domain, hence already synchronous
      next_irq_width = next_irq_flag[IRQ_WIDTH_BIT] & next_irq_enable[IRQ_WIDTH_BIT];
      next_irq_period = next_irq_flag[IRQ_PERIOD_BIT] & next_irq_enable[IRQ_PERIOD_BIT];
      next_irq_match = next_irq_flag[IRQ_MATCH_BIT] & next_irq_enable[IRQ_MATCH_BIT];
      next_clk_req = next_ctl0.en;
   end

   always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
      if (!i_arst_n) begin
         state <= ST_IDLE;
         ctl0 <= REG_RST;
         ctl1 <= REG_RST;
         stat <= REG_RST;
         measure_counter <= CNT_ZERO;
         period_latch <= CNT_ZERO;
         pulse_width_latch <= CNT_ZERO;
         period_limit <= PERIOD_LIMIT_RST;
         presc_cnt <= '0;
         irq_flag <= IRQ_RST;
         irq_enable <= IRQ_RST;
         o_irq_width_acq <= 1'b0;
         o_irq_period_acq <= 1'b0;
         o_irq_match <= 1'b0;
         o_meas_clk_req <= 1'b0;
      end else if (i_ce) begin
         state <= next_state;
         ctl0 <= next_ctl0;
         ctl1 <= next_ctl1;
         stat <= next_stat;
         measure_counter <= next_measure_counter;
         period_latch <= next_period_latch;
         pulse_width_latch <= next_pulse_width_latch;
         period_limit <= next_period_limit;
         presc_cnt <= next_presc_cnt;
         irq_flag <= next_irq_flag;
         irq_enable <= next_irq_enable;
         o_irq_width_acq <= next_irq_width;
         o_irq_period_acq <= next_irq_period;
         o_irq_match <= next_irq_match;
         o_meas_clk_req <= next_clk_req;
      end
   end
endmodule // sgm_signal_measurement_timer
